// ==== hw/flash_lock_host.sv ====
// Host sequencer that drives the flash lock-bit commands and checks status.
`timescale 1ns/1ps
`default_nettype none
`include "lock_host_map.svh"
module flash_lock_host #(
  parameter int          AW        = 20,
  parameter logic [7:0]  OP_SETUP  = `OP_SET_SETUP,
  parameter logic [7:0]  OP_BLOCK  = `OP_SET_BLOCK,
  parameter logic [7:0]  OP_PERM   = `OP_SET_PERM,
  parameter logic [7:0]  OP_CLEAR  = `OP_CLR_CONFIRM,
  parameter logic [7:0]  OP_CLRST  = `OP_CLR_STATUS
) (
  input  wire logic            SYS_CLK,
  input  wire logic            RESET,
  input  wire logic [3:0]      REG_ADDR,
  input  wire logic [31:0]     REG_WDATA,
  input  wire logic            REG_WR,
  input  wire logic            REG_RD,
  output var  logic [31:0]     REG_RDATA,
  output var  logic [AW-1:0]   FLASH_ADDR,
  input  wire logic [7:0]      FLASH_DQ_IN,
  output var  logic [7:0]      FLASH_DQ_OUT,
  output var  logic            FLASH_DQ_OE,
  output var  logic            FLASH_WE_N,
  output var  logic            FLASH_OE_N,
  output var  logic            RESET_POWERDOWN_N
);
  // ****************************************
  // State
  // ****************************************
  // All sequencer state in one record.
  typedef struct packed {
    lock_host_pkg::seq_e  seq;
    lock_host_pkg::cmd_e  cmd;
    logic [AW-1:0]        addr;
    logic                 busy;
    logic                 go;
    logic                 is_read;
    logic [AW-1:0]        cyc_addr;
    logic [7:0]           cyc_data;
    logic [7:0]           status;
    logic                 ok;
    logic                 err;
    logic                 done_evt;
    logic [31:0]          rdata;
    logic                 rst_pin;
  } host_s;
  host_s st_r, st_nxt;
  // Bus cycle engine wires.
  logic              cyc_done;
  logic [7:0]        cyc_rdata;
  logic [AW-1:0]     pin_a;
  logic [7:0]        pin_dq;
  logic              pin_oe;
  logic              pin_we_n;
  logic              pin_oe_n;
  // ****************************************
  // Bus cycle engine
  // ****************************************
  flash_bus_cycle #(.AW(AW)) u_cyc (
    .clk     (SYS_CLK),
    .reset   (RESET),
    .go      (st_r.go),
    .is_read (st_r.is_read),
    .addr    (st_r.cyc_addr),
    .wdata   (st_r.cyc_data),
    .dq_in   (FLASH_DQ_IN),
    .done    (cyc_done),
    .rdata   (cyc_rdata),
    .a_o     (pin_a),
    .dq_o    (pin_dq),
    .dq_oe   (pin_oe),
    .we_n    (pin_we_n),
    .oe_n    (pin_oe_n)
  );
  // The error bit that the finished command must be judged on.
  function automatic logic fail_of(lock_host_pkg::cmd_e c, logic [7:0] s);
    logic f;
    f = 1'b0;
    unique case (c)
      lock_host_pkg::CMD_SET_BLOCK, lock_host_pkg::CMD_SET_PERM: begin
        f = s[`SR_PROG_ERR];
      end
      lock_host_pkg::CMD_CLEAR: begin
        f = s[`SR_ERASE_ERR];
      end
      default: begin
        f = 1'b0;
      end
    endcase
    return f;
  endfunction : fail_of
  // ****************************************
  // Sequencer and registers
  // ****************************************
  // Register writes take orders; the sequencer walks each command.
  always_comb begin
    st_nxt = st_r;
    st_nxt.go = 1'b0;
    st_nxt.done_evt = 1'b0;
    // Read data for a strobe in the previous cycle.
    st_nxt.rdata = 32'h0000_0000;
    if (REG_RD) begin
      unique case (REG_ADDR)
        `REG_STATUS: st_nxt.rdata = {29'h0, st_r.err, st_r.ok, st_r.busy};
        // Reserved lowest bit is masked from the copy.
        `REG_RESULT: st_nxt.rdata = {24'h0, st_r.status & 8'hfe};
        `REG_ADDR:   st_nxt.rdata = 32'(st_r.addr);
        `REG_OPCODES: st_nxt.rdata = {OP_CLEAR, OP_PERM, OP_BLOCK, OP_SETUP};
        default:     st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (REG_WR && REG_ADDR == `REG_ADDR) begin
      st_nxt.addr = REG_WDATA[AW-1:0];
    end
    // Software may pulse the device reset pin low while idle only, so a
    // running clear is never cut short and left undefined.
    if (REG_WR && REG_ADDR == `REG_STATUS && !st_r.busy) begin
      st_nxt.rst_pin = !REG_WDATA[0];
    end
    unique case (st_r.seq)
      lock_host_pkg::ST_IDLE: begin
        if (REG_WR && REG_ADDR == `REG_CTRL && REG_WDATA[`CTRL_START]) begin
          st_nxt.cmd = lock_host_pkg::cmd_e'(
            REG_WDATA[`CTRL_CMD_HI:`CTRL_CMD_LO]);
          st_nxt.busy = 1'b1;
          st_nxt.ok = 1'b0;
          st_nxt.err = 1'b0;
          st_nxt.seq = lock_host_pkg::ST_CYC1;
        end
      end
      lock_host_pkg::ST_CYC1: begin
        // First write: setup, clear status or read status opcode at the block or device address.
        st_nxt.go = 1'b1;
        st_nxt.is_read = 1'b0;
        st_nxt.cyc_addr = st_r.addr;
        unique case (st_r.cmd)
          lock_host_pkg::CMD_SET_BLOCK,
          lock_host_pkg::CMD_SET_PERM: st_nxt.cyc_data = OP_SETUP;
          lock_host_pkg::CMD_CLEAR:    st_nxt.cyc_data = OP_SETUP;
          lock_host_pkg::CMD_CLR_STAT: st_nxt.cyc_data = OP_CLRST;
          default:                     st_nxt.cyc_data = `OP_READ_STATUS;
        endcase
        st_nxt.seq = lock_host_pkg::ST_CYC2;
      end
      lock_host_pkg::ST_CYC2: begin
        if (cyc_done) begin
          // Confirm write for two-cycle commands; clear status finishes here, a lone status command reads at once in ST_CHECK.
          if (st_r.cmd == lock_host_pkg::CMD_SET_BLOCK ||
              st_r.cmd == lock_host_pkg::CMD_SET_PERM ||
              st_r.cmd == lock_host_pkg::CMD_CLEAR) begin
            st_nxt.go = 1'b1;
            st_nxt.is_read = 1'b0;
            st_nxt.cyc_addr = st_r.addr;
            st_nxt.cyc_data = (st_r.cmd == lock_host_pkg::CMD_SET_BLOCK) ?
              OP_BLOCK : (st_r.cmd == lock_host_pkg::CMD_SET_PERM) ?
              OP_PERM : OP_CLEAR;
            st_nxt.cmd = st_r.cmd;
            st_nxt.seq = lock_host_pkg::ST_POLL;
            st_nxt.status = 8'h00;
          end else if (st_r.cmd == lock_host_pkg::CMD_CLR_STAT) begin
            st_nxt.busy = 1'b0;
            st_nxt.ok = 1'b1;
            st_nxt.done_evt = 1'b1;
            st_nxt.seq = lock_host_pkg::ST_IDLE;
          end else begin
            // A lone status command: its write is done, read at once.
            st_nxt.go = 1'b1;
            st_nxt.is_read = 1'b1;
            st_nxt.seq = lock_host_pkg::ST_CHECK;
          end
        end
      end
      lock_host_pkg::ST_POLL: begin
        // Wait for the previous cycle, then issue one status read.
        if (cyc_done) begin
          st_nxt.go = 1'b1;
          st_nxt.is_read = 1'b1;
          st_nxt.seq = lock_host_pkg::ST_CHECK;
        end
      end
      lock_host_pkg::ST_CHECK: begin
        if (cyc_done) begin
          st_nxt.status = cyc_rdata;
          if (cyc_rdata[`SR_READY]) begin
            // Device reads status until a new command.
            st_nxt.busy = 1'b0;
            st_nxt.err = fail_of(st_r.cmd, cyc_rdata);
            st_nxt.ok = !fail_of(st_r.cmd, cyc_rdata);
            st_nxt.done_evt = 1'b1;
            st_nxt.seq = lock_host_pkg::ST_IDLE;
          end else begin
            // Still busy: read again at once.
            st_nxt.go = 1'b1;
            st_nxt.is_read = 1'b1;
          end
        end
      end
      default: begin
        st_nxt.seq = lock_host_pkg::ST_IDLE;
      end
    endcase
  end
  // Register the state.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      st_r <= '{seq: lock_host_pkg::ST_IDLE, cmd: lock_host_pkg::CMD_POLL,
                addr: '0, busy: 1'b0, go: 1'b0, is_read: 1'b0,
                cyc_addr: '0, cyc_data: 8'h00, status: 8'h00, ok: 1'b0,
                err: 1'b0, done_evt: 1'b0, rdata: 32'h0, rst_pin: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end
  // Pin outputs come from flip-flops in the cycle engine or here.
  assign REG_RDATA         = st_r.rdata;
  assign FLASH_ADDR        = pin_a;
  assign FLASH_DQ_OUT      = pin_dq;
  assign FLASH_DQ_OE       = pin_oe;
  assign FLASH_WE_N        = pin_we_n;
  assign FLASH_OE_N        = pin_oe_n;
  assign RESET_POWERDOWN_N = st_r.rst_pin;
  // ****************************************
  // Checks
  // ****************************************
  confirm_follows_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (st_r.seq == lock_host_pkg::ST_CYC2 && cyc_done &&
     st_r.cmd == lock_host_pkg::CMD_CLEAR) |=> st_r.go &&
     st_r.cyc_data == OP_CLEAR)
    else $error("Clear confirm did not follow the setup.");
  set_confirm_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (st_r.seq == lock_host_pkg::ST_CYC2 && cyc_done &&
     st_r.cmd == lock_host_pkg::CMD_SET_PERM) |=> st_r.cyc_data == OP_PERM)
    else $error("Permanent confirm opcode wrong.");
  prog_check_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (st_r.seq == lock_host_pkg::ST_CHECK && cyc_done && cyc_rdata[7] &&
     st_r.cmd == lock_host_pkg::CMD_SET_BLOCK) |=> st_r.err == $past(cyc_rdata[4]))
    else $error("Program error not reported after set.");
  erase_check_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (st_r.seq == lock_host_pkg::ST_CHECK && cyc_done && cyc_rdata[7] &&
     st_r.cmd == lock_host_pkg::CMD_CLEAR) |=> st_r.err == $past(cyc_rdata[5]))
    else $error("Erase error not reported after clear.");
  ready_wait_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (st_r.seq == lock_host_pkg::ST_CHECK && cyc_done && !cyc_rdata[7])
    |=> st_r.busy && st_r.go)
    else $error("Host stopped polling while device busy.");
  mask_bit_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    $past(REG_RD) && $past(REG_ADDR) == `REG_RESULT |-> !REG_RDATA[0])
    else $error("Reserved status bit not masked.");
  read_once_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("Read data outside its cycle.");
  start_busy_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (REG_WR && REG_ADDR == `REG_CTRL && REG_WDATA[0] && !st_r.busy)
    |=> st_r.busy ##1 st_r.go)
    else $error("Start did not launch a setup write.");
  cover_set_c: cover property (@(posedge SYS_CLK)
    st_r.done_evt && st_r.cmd == lock_host_pkg::CMD_SET_BLOCK);
  cover_clear_c: cover property (@(posedge SYS_CLK)
    st_r.done_evt && st_r.cmd == lock_host_pkg::CMD_CLEAR && st_r.err);
  cover_perm_c: cover property (@(posedge SYS_CLK)
    st_r.done_evt && st_r.cmd == lock_host_pkg::CMD_SET_PERM);
  cover_poll_c: cover property (@(posedge SYS_CLK)
    st_r.done_evt && st_r.cmd == lock_host_pkg::CMD_POLL);
endmodule : flash_lock_host
`default_nettype wire

// ==== hw/lock_host_map.svh ====
// Offsets, field positions, opcodes and timing counts of the lock host.
`ifndef LOCK_HOST_MAP_SVH
`define LOCK_HOST_MAP_SVH
// Host command register offsets.
`define REG_CTRL     4'h0
`define REG_ADDR     4'h1
`define REG_STATUS   4'h2
`define REG_RESULT   4'h3
`define REG_OPCODES  4'h4
// Control register fields: start bit and command code.
`define CTRL_START   0
`define CTRL_CMD_LO  1
`define CTRL_CMD_HI  3
// Device status bit positions.
`define SR_READY     7
`define SR_ERASE_ERR 5
`define SR_PROG_ERR  4
`define SR_SUPPLY    3
`define SR_PROTECT   1
// Default opcodes; the host takes all but read status as parameters.
`define OP_SET_SETUP   8'h60
`define OP_SET_BLOCK   8'h01
`define OP_SET_PERM    8'hf1
`define OP_CLR_CONFIRM 8'hd0
`define OP_CLR_STATUS  8'h50
`define OP_READ_STATUS 8'h70
// Bus strobe timing: write strobe low time and read access time.
`define T_STROBE_NS  60
`define T_ACCESS_NS  100
`define CLK_NS       10
`define STROBE_CYC   ((`T_STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define ACCESS_CYC   ((`T_ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ==== hw/lock_host_pkg.sv ====
// Types shared by the lock host files.
package lock_host_pkg;
  // Commands that software may order.
  typedef enum logic [2:0] {
    CMD_SET_BLOCK = 3'b000,
    CMD_SET_PERM  = 3'b001,
    CMD_CLEAR     = 3'b010,
    CMD_CLR_STAT  = 3'b011,
    CMD_POLL      = 3'b100
  } cmd_e;
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CYC1  = 3'b001,
    ST_CYC2  = 3'b010,
    ST_POLL  = 3'b011,
    ST_CHECK = 3'b100
  } seq_e;
  // One bus cycle result kind.
  typedef logic [7:0] byte_t;
endpackage : lock_host_pkg

// ==== hw/flash_bus_cycle.sv ====
// One timed write or read cycle on the asynchronous flash bus.
`timescale 1ns/1ps
`default_nettype none
`include "lock_host_map.svh"
module flash_bus_cycle #(
  parameter int AW = 20
) (
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            go,
  input  wire logic            is_read,
  input  wire logic [AW-1:0]   addr,
  input  wire logic [7:0]      wdata,
  input  wire logic [7:0]      dq_in,
  output var  logic            done,
  output var  logic [7:0]      rdata,
  output var  logic [AW-1:0]   a_o,
  output var  logic [7:0]      dq_o,
  output var  logic            dq_oe,
  output var  logic            we_n,
  output var  logic            oe_n
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic            busy;
    logic [3:0]      cnt;
    logic            rd;
    logic            done;
    logic [7:0]      rdata;
    logic [AW-1:0]   a;
    logic [7:0]      dq;
    logic            oe_en;
    logic            we_n;
    logic            oe_n;
  } cyc_s;
  cyc_s st_r, st_nxt;
  localparam logic [3:0] WCYC = 4'(`STROBE_CYC);
  localparam logic [3:0] RCYC = 4'(`ACCESS_CYC);
  // The address field must fit the 32-bit register copy in the host.
  if (AW < 4 || AW > 32) begin : g_aw_check
    $error("flash_bus_cycle: AW out of range.");
  end
  // Strobe is held for its least time, then released with done.
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (!st_r.busy && go) begin
      st_nxt.busy = 1'b1;
      st_nxt.rd = is_read;
      st_nxt.a = addr;
      st_nxt.dq = wdata;
      st_nxt.oe_en = !is_read;
      st_nxt.we_n = is_read;
      st_nxt.oe_n = !is_read;
      st_nxt.cnt = is_read ? RCYC : WCYC;
    end else if (st_r.busy) begin
      if (st_r.cnt > 4'h1) begin
        st_nxt.cnt = st_r.cnt - 4'h1;
      end else begin
        // Data is sampled before the output enable is dropped.
        if (st_r.rd) begin
          st_nxt.rdata = dq_in;
        end
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
        st_nxt.we_n = 1'b1;
        st_nxt.oe_n = 1'b1;
        // Data keeps driving through the rising write strobe, where the
        // device latches it; dropping both together would race.
      end
    end else begin
      // Idle cycle after a transfer: the data drive is released here.
      st_nxt.oe_en = 1'b0;
    end
  end
  // Register the state.
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '{busy: 1'b0, cnt: 4'h0, rd: 1'b0, done: 1'b0, rdata: 8'h00,
                a: '0, dq: 8'h00, oe_en: 1'b0, we_n: 1'b1, oe_n: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign done  = st_r.done;
  assign rdata = st_r.rdata;
  assign a_o   = st_r.a;
  assign dq_o  = st_r.dq;
  assign dq_oe = st_r.oe_en;
  assign we_n  = st_r.we_n;
  assign oe_n  = st_r.oe_n;
  // ****************************************
  // Checks
  // ****************************************
  strobe_excl_a: assert property (@(posedge clk) disable iff (reset)
    !(st_r.we_n == 1'b0 && st_r.oe_n == 1'b0))
    else $error("Write and read strobe low together.");
  drive_write_a: assert property (@(posedge clk) disable iff (reset)
    !st_r.we_n |-> st_r.oe_en)
    else $error("Write strobe low without data driven.");
endmodule : flash_bus_cycle
`default_nettype wire

// ==== verification/flash_lock_device.sv ====
// Behavioural model of the flash device lock-bit logic facing the host.
`timescale 1ns/1ps
`default_nettype none
`include "lock_host_map.svh"
module flash_lock_device #(
  parameter int AW = 20
) (
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    dq,
  input  wire logic          we_n,
  input  wire logic          oe_n,
  input  wire logic          rp_n,
  input  wire logic          supply_ok,
  input  wire logic          boot_protect_n,
  input  wire logic [3:0]    slow,
  output var  logic [7:0]    q
);
  // ****************************************
  // Device state
  // ****************************************
  logic [7:0]       lock_r = 8'h00; // One lock bit per block.
  logic             perm_r = 1'b0;  // Permanent lock bit.
  logic [7:0]       sr_r   = 8'h00; // Sticky error flags.
  logic             arm_r  = 1'b0;  // A setup write was seen.
  logic             clr_r  = 1'b0;  // A clear is still running.
  logic [3:0]       wait_r = 4'h0;  // Status reads owed before ready.
  logic             rsv_r  = 1'b0;  // Reserved bit, noise on purpose.
  logic [7:0]       last_r = 8'h00; // Last byte put on the bus.
  int               n_ops  = 0;     // Confirmed sequences seen.
  logic [7:0]       stat;           // Status byte as read.
  wire logic [2:0]  blk = addr[AW-1:AW-3];
  // Top-boot build: the two highest blocks are the boot blocks.
  localparam logic [7:0] BOOT = 8'hc0;
  // Blocks open to program or erase now; full chip erase would touch
  // exactly these, so the bench holds the lock state against them.
  wire logic [7:0]  alter_ok = (supply_ok && rp_n === 1'b1) ?
    (~lock_r & (boot_protect_n ? 8'hff : ~BOOT)) :
    8'h00;
  // Ready once no reads are owed; the reserved bit toggles every read.
  assign stat = {wait_r == 4'h0, 1'b0, sr_r[5:1], rsv_r};
  // A released bus shows the inverse of the last byte, never a copy.
  assign q = oe_n ? ~last_r : stat;
  // The end of each read counts down the busy time.
  always @(posedge oe_n) begin
    last_r <= stat;
    rsv_r <= ~rsv_r;
    if (wait_r != 4'h0) wait_r <= wait_r - 4'h1;
    if (wait_r == 4'h1) clr_r <= 1'b0;
  end
  // The reset pin drops a half-written sequence and spoils a clear.
  always @(negedge rp_n) begin
    arm_r <= 1'b0;
    if (clr_r) lock_r <= 8'hxx;
  end
  // Commands are latched on the rising write strobe.
  always @(posedge we_n) begin
    if (rp_n === 1'b1) begin
      arm_r <= 1'b0;
      if (arm_r) begin
        n_ops <= n_ops + 1;
        wait_r <= slow;
        case (dq)
          `OP_SET_BLOCK: begin
            if (!supply_ok) sr_r <= sr_r | 8'h18;
            else if (perm_r) sr_r <= sr_r | 8'h12;
            else lock_r[blk] <= 1'b1;
          end
          `OP_SET_PERM: begin
            if (!supply_ok) sr_r <= sr_r | 8'h18;
            else perm_r <= 1'b1;
          end
          `OP_CLR_CONFIRM: begin
            if (!supply_ok) sr_r <= sr_r | 8'h28;
            else if (perm_r) sr_r <= sr_r | 8'h22;
            else begin
              lock_r <= 8'h00;
              clr_r <= (slow != 4'h0);
            end
          end
          default: sr_r <= sr_r | 8'h30;
        endcase
      end else if (dq == `OP_CLR_STATUS) sr_r <= 8'h00;
      else if (dq == `OP_SET_SETUP) arm_r <= 1'b1;
    end
  end
endmodule : flash_lock_device
`default_nettype wire

// ==== verification/flash_lock_host_tb.sv ====
// Self-checking bench for the flash lock host against the device model.
`timescale 1ns/1ps
`default_nettype none
module flash_lock_host_tb;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam lock_host_pkg::cmd_e SB = lock_host_pkg::CMD_SET_BLOCK;
  localparam lock_host_pkg::cmd_e PM = lock_host_pkg::CMD_SET_PERM;
  localparam lock_host_pkg::cmd_e CL = lock_host_pkg::CMD_CLEAR;
  localparam lock_host_pkg::cmd_e CS = lock_host_pkg::CMD_CLR_STAT;
  localparam lock_host_pkg::cmd_e PL = lock_host_pkg::CMD_POLL;
  typedef struct {
    lock_host_pkg::cmd_e cmd; // Command ordered.
    logic [19:0] adr;         // Target address.
    logic        sup;         // Program supply above lockout.
    logic [7:0]  res;         // Status byte expected in RESULT.
    logic        err;         // Error expected.
    logic [7:0]  lk;          // Lock bits expected afterwards.
    logic [1:0]  chk;         // 0 none, 1 byte and locks, 2 all.
  } row_s;
  logic        sys_clk   = 1'b0;
  logic        reset     = 1'b1;
  logic [3:0]  reg_addr  = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        supply_ok = 1'b1;
  logic [3:0]  slow      = 4'h0;
  logic        boot_protect_n = 1'b1;
  logic [31:0] reg_rdata;
  logic [19:0] f_addr;
  logic [7:0]  dq_out;
  logic [7:0]  dev_q;
  logic        dq_oe;
  logic        we_n;
  logic        oe_n;
  logic        rp_n;
  int          n_mismatch   = 0;
  int          total_checks = 0;
  // The host wins the data wire while it drives it.
  wire logic [7:0] dq_wire = dq_oe ? dq_out : dev_q;
  row_s rows [16] = '{
    '{SB, 20'h40000, 1'b1, 8'h80, 1'b0, 8'h04, 2'd2},
    '{CL, 20'h00000, 1'b0, 8'ha8, 1'b1, 8'h04, 2'd2},
    '{CS, 20'h00000, 1'b1, 8'h00, 1'b0, 8'h04, 2'd0},
    '{PL, 20'h00000, 1'b1, 8'h80, 1'b0, 8'h04, 2'd1},
    '{SB, 20'ha0000, 1'b0, 8'h98, 1'b1, 8'h04, 2'd2},
    '{CS, 20'h00000, 1'b1, 8'h00, 1'b0, 8'h04, 2'd0},
    '{SB, 20'ha0000, 1'b1, 8'h80, 1'b0, 8'h24, 2'd2},
    '{CL, 20'h00000, 1'b1, 8'h80, 1'b0, 8'h00, 2'd2},
    '{PM, 20'h00000, 1'b0, 8'h98, 1'b1, 8'h00, 2'd2},
    '{CS, 20'h00000, 1'b1, 8'h00, 1'b0, 8'h00, 2'd0},
    '{SB, 20'ha0000, 1'b1, 8'h80, 1'b0, 8'h20, 2'd2},
    '{PM, 20'h00000, 1'b1, 8'h80, 1'b0, 8'h20, 2'd2},
    '{SB, 20'h20000, 1'b1, 8'h92, 1'b1, 8'h20, 2'd2},
    '{CS, 20'h00000, 1'b1, 8'h00, 1'b0, 8'h20, 2'd0},
    '{CL, 20'h00000, 1'b1, 8'ha2, 1'b1, 8'h20, 2'd2},
    '{CS, 20'h00000, 1'b1, 8'h00, 1'b0, 8'h20, 2'd0}
  };
  always #5 sys_clk = ~sys_clk;
  flash_lock_host dut (
    .SYS_CLK(sys_clk), .RESET(reset), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .FLASH_ADDR(f_addr), .FLASH_DQ_IN(dq_wire),
    .FLASH_DQ_OUT(dq_out), .FLASH_DQ_OE(dq_oe), .FLASH_WE_N(we_n),
    .FLASH_OE_N(oe_n), .RESET_POWERDOWN_N(rp_n)
  );
  flash_lock_device dev (
    .addr(f_addr), .dq(dq_wire), .we_n(we_n), .oe_n(oe_n), .rp_n(rp_n),
    .supply_ok(supply_ok), .boot_protect_n(boot_protect_n), .slow(slow),
    .q(dev_q)
  );
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // Polls the busy bit; a hang is reported and ends the run.
  task automatic wait_idle(output logic [31:0] st);
    int n;
    for (n = 0; n < 3000; n++) begin
      rd(4'h2, st);
      if (st[0] === 1'b0) break;
    end
    if (n == 3000) begin
      chk("idle", 32'h1, 32'h0);
      end_of_test();
    end
  endtask : wait_idle
  task automatic run(input row_s r, input logic odd);
    logic [31:0] st;
    logic [31:0] v;
    @(posedge sys_clk);
    supply_ok <= r.sup;
    slow <= odd ? 4'h5 : 4'h0;
    wr(4'h1, {12'h0, r.adr});
    wr(4'h0, {28'h0, r.cmd, 1'b1});
    wait_idle(st);
    if (r.chk != 2'd0) begin
      rd(4'h3, v);
      chk("result", v, {24'h0, r.res});
      chk("locks", {24'h0, dev.lock_r}, {24'h0, r.lk});
    end
    if (r.chk == 2'd2) begin
      chk("err", {31'h0, st[2]}, {31'h0, r.err});
      chk("ok", {31'h0, st[1]}, {31'h0, ~r.err});
    end
  endtask : run
  task automatic end_of_test();
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] v;
    int          ops;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    rd(4'h2, v);
    chk("status", v, 32'h0);
    chk("rp_n", {31'h0, rp_n}, 32'h1);
    rd(4'h4, v);
    chk("opcodes", v, 32'hd0f10160);
    // A write to an unmapped index must change nothing.
    wr(4'h9, 32'hffffffff);
    rd(4'h4, v);
    chk("opcodes", v, 32'hd0f10160);
    for (int i = 0; i < 16; i++) begin
      run(rows[i], i[0]);
    end
    // A second start while busy is ignored: one sequence only.
    ops = dev.n_ops;
    wr(4'h1, 32'h0);
    wr(4'h0, {28'h0, SB, 1'b1});
    wr(4'h0, {28'h0, CL, 1'b1});
    wait_idle(v);
    chk("ops", 32'(dev.n_ops - ops), 32'h1);
    chk("locks", {24'h0, dev.lock_r}, 32'h20);
    chk("perm", {31'h0, dev.perm_r}, 32'h1);
    // The reset pin follows the inverse of status register bit 0 while idle.
    wr(4'h2, 32'h1);
    repeat (2) @(posedge sys_clk);
    #1 chk("rp_n", {31'h0, rp_n}, 32'h0);
    chk("alter", {24'h0, dev.alter_ok}, 32'h0);
    wr(4'h2, 32'h0);
    repeat (2) @(posedge sys_clk);
    #1 chk("rp_n", {31'h0, rp_n}, 32'h1);
    // Only block 5 is locked; the boot pin then shuts the top two.
    chk("alter", {24'h0, dev.alter_ok}, 32'hdf);
    @(posedge sys_clk);
    boot_protect_n <= 1'b0;
    @(posedge sys_clk);
    #1 chk("alter", {24'h0, dev.alter_ok}, 32'h1f);
    end_of_test();
  end
endmodule : flash_lock_host_tb
`default_nettype wire
